// ---- bpc_regs.sv ----
// Peak-current configuration register bank for two buck channels.
// Assumes a decoded serial register port: addr, write strobe, write data, read data.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Channel 1 level register holds 9-bit peak level; bit 9 reads zero.
// - Channel 2 level register holds 9-bit peak level; bit 9 reads zero.
// - Level scales linearly 0..511; each higher range doubles current.
// - Channel 1 range code in bits 5:3, codes 000..100 are ranges 1..5.
// - Channel 2 range code in bits 2:0, codes 000..100 are ranges 1..5.
// - Channel 1 range pends until next channel 1 level write.
// - Channel 2 range pends until next channel 2 level write.
// - Bit 7 enables channel 1 low-side pre-driver at low string voltage.
// - Bit 6 enables channel 2 low-side pre-driver at low string voltage.
module bpc_regs
   import bpc_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   input  wire logic                   failsafe_state,
   input  wire logic [BPC_ADDR_W-1:0]  reg_addr,
   input  wire logic                   reg_we,
   input  wire logic [BPC_DATA_W-1:0]  reg_wdata,
   output logic      [BPC_DATA_W-1:0]  reg_rdata,
   output logic      [BPC_LEVEL_W-1:0] ch1_peak_level,
   output logic      [BPC_LEVEL_W-1:0] ch2_peak_level,
   output logic      [BPC_RANGE_W-1:0] ch1_peak_scale,
   output logic      [BPC_RANGE_W-1:0] ch2_peak_scale,
   output logic                        ch1_lowside_lowvolt_en,
   output logic                        ch2_lowside_lowvolt_en
);

   //////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic hit(input logic [BPC_ADDR_W-1:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [BPC_RANGE_W-1:0] clamp_rng(input logic [BPC_RANGE_W-1:0] c);
      clamp_rng = (c > BPC_RANGE_MAX) ? BPC_RANGE_MAX : c;
   endfunction

   logic                   we_l1;
   logic                   we_l2;
   logic                   we_rg;
   logic [BPC_LEVEL_W-1:0] lvl_q   [2];
   logic [BPC_RANGE_W-1:0] pend_q  [2];
   logic [BPC_RANGE_W-1:0] scale_q [2];
   logic                   ls1_q;
   logic                   ls2_q;
   logic                   ls1_d;
   logic                   ls2_d;
   logic [BPC_DATA_W-1:0]  rdata_d;

   assign we_l1 = reg_we && hit(reg_addr, BPC_OFF_CH1_LEVEL);
   assign we_l2 = reg_we && hit(reg_addr, BPC_OFF_CH2_LEVEL);
   assign we_rg = reg_we && hit(reg_addr, BPC_OFF_RANGE);

   //////////////////////////////////////////////////////////////////////////
   // Channels

   bpc_channel u_ch1 (
      .core_clk       (core_clk),
      .reset          (reset),
      .failsafe_state (failsafe_state),
      .level_we       (we_l1),
      .range_we       (we_rg),
      .level_wdata    (reg_wdata[BPC_LEVEL_W-1:0]),
      .range_wdata    (clamp_rng(reg_wdata[BPC_CH1_RNG_LSB +: BPC_RANGE_W])),
      .level_fso_mask (BPC_FSO_MASK_LVL[BPC_LEVEL_W-1:0]),
      .range_fso_mask (BPC_FSO_MASK_RNG[BPC_CH1_RNG_LSB +: BPC_RANGE_W]),
      .level_q        (lvl_q[0]),
      .pend_q         (pend_q[0]),
      .scale_q        (scale_q[0])
   );

   bpc_channel u_ch2 (
      .core_clk       (core_clk),
      .reset          (reset),
      .failsafe_state (failsafe_state),
      .level_we       (we_l2),
      .range_we       (we_rg),
      .level_wdata    (reg_wdata[BPC_LEVEL_W-1:0]),
      .range_wdata    (clamp_rng(reg_wdata[BPC_CH2_RNG_LSB +: BPC_RANGE_W])),
      .level_fso_mask (BPC_FSO_MASK_LVL[BPC_LEVEL_W-1:0]),
      .range_fso_mask (BPC_FSO_MASK_RNG[BPC_CH2_RNG_LSB +: BPC_RANGE_W]),
      .level_q        (lvl_q[1]),
      .pend_q         (pend_q[1]),
      .scale_q        (scale_q[1])
   );

   //////////////////////////////////////////////////////////////////////////
   // Low-side enables and read data

   always_comb begin
      ls1_d = ls1_q;
      ls2_d = ls2_q;
      if (we_rg) begin
         ls1_d = reg_wdata[BPC_CH1_LS_BIT];
         ls2_d = reg_wdata[BPC_CH2_LS_BIT];
      end
      rdata_d = '0;
      case (reg_addr)
         BPC_OFF_CH1_LEVEL: begin
            rdata_d[BPC_LEVEL_W-1:0] = lvl_q[0];
         end
         BPC_OFF_CH2_LEVEL: begin
            rdata_d[BPC_LEVEL_W-1:0] = lvl_q[1];
         end
         BPC_OFF_RANGE: begin
            rdata_d[BPC_CH1_LS_BIT] = ls1_q;
            rdata_d[BPC_CH2_LS_BIT] = ls2_q;
            rdata_d[BPC_CH1_RNG_LSB +: BPC_RANGE_W] = pend_q[0];
            rdata_d[BPC_CH2_RNG_LSB +: BPC_RANGE_W] = pend_q[1];
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ls1_q                  <= 1'b0;
         ls2_q                  <= 1'b0;
         reg_rdata              <= '0;
         ch1_peak_level         <= BPC_LEVEL_RST;
         ch2_peak_level         <= BPC_LEVEL_RST;
         ch1_peak_scale         <= BPC_RANGE_RST;
         ch2_peak_scale         <= BPC_RANGE_RST;
         ch1_lowside_lowvolt_en <= 1'b0;
         ch2_lowside_lowvolt_en <= 1'b0;
      end else begin
         ls1_q                  <= ls1_d;
         ls2_q                  <= ls2_d;
         reg_rdata              <= rdata_d;
         ch1_peak_level         <= lvl_q[0];
         ch2_peak_level         <= lvl_q[1];
         ch1_peak_scale         <= scale_q[0];
         ch2_peak_scale         <= scale_q[1];
         ch1_lowside_lowvolt_en <= ls1_q;
         ch2_lowside_lowvolt_en <= ls2_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks

   AST_CH1_PEND_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      (!we_l1 && !failsafe_state) |=> ##1 (ch1_peak_scale == $past(ch1_peak_scale)))
      else $error("channel 1 range changed without a level write");
   AST_CH2_PEND_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      (!we_l2 && !failsafe_state) |=> ##1 (ch2_peak_scale == $past(ch2_peak_scale)))
      else $error("channel 2 range changed without a level write");
   AST_CH1_APPLY: assert property (@(posedge core_clk) disable iff (reset)
      (we_l1 && !we_rg && !failsafe_state) |-> ##2 (ch1_peak_scale == $past(pend_q[0], 2)))
      else $error("channel 1 pending range not applied");
   AST_CH2_APPLY: assert property (@(posedge core_clk) disable iff (reset)
      (we_l2 && !we_rg && !failsafe_state) |-> ##2 (ch2_peak_scale == $past(pend_q[1], 2)))
      else $error("channel 2 pending range not applied");
   AST_CH1_LEVEL: assert property (@(posedge core_clk) disable iff (reset)
      (we_l1 && !failsafe_state) |-> ##2 (ch1_peak_level == $past(reg_wdata[8:0], 2)))
      else $error("channel 1 level not stored");
   AST_CH2_LEVEL: assert property (@(posedge core_clk) disable iff (reset)
      (we_l2 && !failsafe_state) |-> ##2 (ch2_peak_level == $past(reg_wdata[8:0], 2)))
      else $error("channel 2 level not stored");
   AST_LS1: assert property (@(posedge core_clk) disable iff (reset)
      we_rg |-> ##2 (ch1_lowside_lowvolt_en == $past(reg_wdata[7], 2)))
      else $error("channel 1 low-side enable wrong");
   AST_LS2: assert property (@(posedge core_clk) disable iff (reset)
      we_rg |-> ##2 (ch2_lowside_lowvolt_en == $past(reg_wdata[6], 2)))
      else $error("channel 2 low-side enable wrong");
   AST_SCALE_MAX: assert property (@(posedge core_clk) disable iff (reset)
      (ch1_peak_scale <= BPC_RANGE_MAX) && (ch2_peak_scale <= BPC_RANGE_MAX))
      else $error("range code above highest range");
   AST_FSO_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
      failsafe_state |-> ##2 (ch1_peak_level[8:1] == 8'h00 && ch2_peak_level[8:1] == 8'h00))
      else $error("fail-safe did not clear levels");
   AST_RD_B9: assert property (@(posedge core_clk) disable iff (reset)
      ##1 (reg_rdata[9] == 1'b0))
      else $error("bit 9 read non-zero");

   //////////////////////////////////////////////////////////////////////////
   // Pending range loading and clamping

   AST_CH1_PEND_LOAD: assert property (@(posedge core_clk) disable iff (reset)
      (we_rg && !failsafe_state && reg_wdata[BPC_CH1_RNG_LSB +: BPC_RANGE_W] <= BPC_RANGE_MAX)
      |=> (pend_q[0] == $past(reg_wdata[BPC_CH1_RNG_LSB +: BPC_RANGE_W])))
      else $error("channel 1 pending range not loaded");
   AST_CH2_PEND_LOAD: assert property (@(posedge core_clk) disable iff (reset)
      (we_rg && !failsafe_state && reg_wdata[BPC_CH2_RNG_LSB +: BPC_RANGE_W] <= BPC_RANGE_MAX)
      |=> (pend_q[1] == $past(reg_wdata[BPC_CH2_RNG_LSB +: BPC_RANGE_W])))
      else $error("channel 2 pending range not loaded");
   AST_CH1_PEND_CLAMP: assert property (@(posedge core_clk) disable iff (reset)
      (we_rg && !failsafe_state && reg_wdata[BPC_CH1_RNG_LSB +: BPC_RANGE_W] > BPC_RANGE_MAX)
      |=> (pend_q[0] == BPC_RANGE_MAX))
      else $error("channel 1 range code above highest not clamped");
   AST_CH2_PEND_CLAMP: assert property (@(posedge core_clk) disable iff (reset)
      (we_rg && !failsafe_state && reg_wdata[BPC_CH2_RNG_LSB +: BPC_RANGE_W] > BPC_RANGE_MAX)
      |=> (pend_q[1] == BPC_RANGE_MAX))
      else $error("channel 2 range code above highest not clamped");

   //////////////////////////////////////////////////////////////////////////
   // Outputs hold between writes

   AST_CH1_LEVEL_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      (!we_l1 && !failsafe_state)
      |=> ##1 (ch1_peak_level == $past(ch1_peak_level)))
      else $error("channel 1 level changed without a write");
   AST_CH2_LEVEL_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      (!we_l2 && !failsafe_state)
      |=> ##1 (ch2_peak_level == $past(ch2_peak_level)))
      else $error("channel 2 level changed without a write");
   AST_LS1_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      !we_rg
      |=> ##1 (ch1_lowside_lowvolt_en == $past(ch1_lowside_lowvolt_en)))
      else $error("channel 1 low-side enable changed without a write");
   AST_LS2_HOLD: assert property (@(posedge core_clk) disable iff (reset)
      !we_rg
      |=> ##1 (ch2_lowside_lowvolt_en == $past(ch2_lowside_lowvolt_en)))
      else $error("channel 2 low-side enable changed without a write");

   //////////////////////////////////////////////////////////////////////////
   // Read-back

   AST_RD_CH1: assert property (@(posedge core_clk) disable iff (reset)
      (reg_addr == BPC_OFF_CH1_LEVEL)
      |=> (reg_rdata == {1'b0, $past(lvl_q[0])}))
      else $error("channel 1 level read-back wrong");
   AST_RD_CH2: assert property (@(posedge core_clk) disable iff (reset)
      (reg_addr == BPC_OFF_CH2_LEVEL)
      |=> (reg_rdata == {1'b0, $past(lvl_q[1])}))
      else $error("channel 2 level read-back wrong");
   AST_RD_RANGE: assert property (@(posedge core_clk) disable iff (reset)
      (reg_addr == BPC_OFF_RANGE)
      |=> (reg_rdata == {2'b00, $past(ls1_q), $past(ls2_q), $past(pend_q[0]), $past(pend_q[1])}))
      else $error("range register read-back wrong");
   AST_RD_UNMAPPED: assert property (@(posedge core_clk) disable iff (reset)
      (reg_addr != BPC_OFF_CH1_LEVEL && reg_addr != BPC_OFF_CH2_LEVEL && reg_addr != BPC_OFF_RANGE)
      |=> (reg_rdata == 10'h000))
      else $error("unmapped address read non-zero");

   //////////////////////////////////////////////////////////////////////////
   // Reset and fail-safe

   AST_RESET_OUT: assert property (@(posedge core_clk) disable iff (reset)
      $fell(reset)
      |-> (ch1_peak_level == BPC_LEVEL_RST && ch2_peak_level == BPC_LEVEL_RST
           && ch1_peak_scale == BPC_RANGE_RST && ch2_peak_scale == BPC_RANGE_RST
           && !ch1_lowside_lowvolt_en && !ch2_lowside_lowvolt_en && reg_rdata == 10'h000))
      else $error("outputs not cleared by reset");
   AST_FSO_PEND: assert property (@(posedge core_clk) disable iff (reset)
      failsafe_state
      |=> (pend_q[0][1:0] == 2'b00 && pend_q[1][1:0] == 2'b00))
      else $error("fail-safe did not clear pending ranges");
   AST_FSO_SCALE: assert property (@(posedge core_clk) disable iff (reset)
      failsafe_state
      |-> ##2 (ch1_peak_scale[1:0] == 2'b00 && ch2_peak_scale[1:0] == 2'b00))
      else $error("fail-safe did not clear active ranges");
   AST_FSO_KEEP_LS: assert property (@(posedge core_clk) disable iff (reset)
      (failsafe_state && !we_rg)
      |=> (ls1_q == $past(ls1_q) && ls2_q == $past(ls2_q)))
      else $error("fail-safe changed a low-side enable");
   AST_FSO_KEEP_B0: assert property (@(posedge core_clk) disable iff (reset)
      (failsafe_state && !we_l1 && !we_l2)
      |-> ##2 (ch1_peak_level[0] == $past(lvl_q[0][0], 2) && ch2_peak_level[0] == $past(lvl_q[1][0], 2)))
      else $error("fail-safe cleared level bit 0");

   COV_CH1_APPLY: cover property (@(posedge core_clk) disable iff (reset) we_rg ##[1:4] we_l1);
   COV_CH2_APPLY: cover property (@(posedge core_clk) disable iff (reset) we_rg ##[1:4] we_l2);
   COV_FSO: cover property (@(posedge core_clk) disable iff (reset) $rose(failsafe_state));
   COV_CLAMP: cover property (@(posedge core_clk) disable iff (reset)
      we_rg && (reg_wdata[BPC_CH1_RNG_LSB +: BPC_RANGE_W] > BPC_RANGE_MAX));
   COV_RD_RANGE: cover property (@(posedge core_clk) disable iff (reset)
      (reg_addr == BPC_OFF_RANGE) ##1 (reg_rdata != 10'h000));

endmodule

// ---- bpc_pkg.sv ----
// Package for the peak-current configuration register bank.
// Assumes a single core clock and an active-high asynchronous reset.
package bpc_pkg;

   localparam int          BPC_ADDR_W       = 5;
   localparam int          BPC_DATA_W       = 10;
   localparam int          BPC_LEVEL_W      = 9;
   localparam int          BPC_RANGE_W      = 3;

   localparam logic [4:0]  BPC_OFF_CH1_LEVEL = 5'h01;
   localparam logic [4:0]  BPC_OFF_CH2_LEVEL = 5'h02;
   localparam logic [4:0]  BPC_OFF_RANGE     = 5'h03;

   localparam int          BPC_LEVEL_LSB    = 0;
   localparam int          BPC_CH1_RNG_LSB  = 3;
   localparam int          BPC_CH2_RNG_LSB  = 0;
   localparam int          BPC_CH1_LS_BIT   = 7;
   localparam int          BPC_CH2_LS_BIT   = 6;

   localparam logic [8:0]  BPC_LEVEL_RST    = 9'h000;
   localparam logic [2:0]  BPC_RANGE_RST    = 3'h0;
   localparam logic [2:0]  BPC_RANGE_MAX    = 3'h4;
   localparam logic [9:0]  BPC_FSO_MASK_LVL = 10'h1FE;
   localparam logic [9:0]  BPC_FSO_MASK_RNG = 10'h01B;

   typedef enum logic [1:0] {
      BPC_ST_IDLE   = 2'b00,
      BPC_ST_FAILSF = 2'b01
   } bpc_mode_t;

endpackage

// ---- bpc_channel.sv ----
// One channel: level register, pending and active range.
// Assumes decoded single-cycle write strobes from the bank.
`timescale 1ns/1ps
module bpc_channel
   import bpc_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   input  wire logic                   failsafe_state,
   input  wire logic                   level_we,
   input  wire logic                   range_we,
   input  wire logic [BPC_LEVEL_W-1:0] level_wdata,
   input  wire logic [BPC_RANGE_W-1:0] range_wdata,
   input  wire logic [BPC_LEVEL_W-1:0] level_fso_mask,
   input  wire logic [BPC_RANGE_W-1:0] range_fso_mask,
   output logic      [BPC_LEVEL_W-1:0] level_q,
   output logic      [BPC_RANGE_W-1:0] pend_q,
   output logic      [BPC_RANGE_W-1:0] scale_q
);

   logic [BPC_LEVEL_W-1:0] level_d;
   logic [BPC_RANGE_W-1:0] pend_d;
   logic [BPC_RANGE_W-1:0] scale_d;

   always_comb begin
      level_d = level_q;
      pend_d  = pend_q;
      scale_d = scale_q;
      if (range_we) begin
         pend_d = range_wdata;
      end
      if (level_we) begin
         level_d = level_wdata;
         scale_d = range_we ? range_wdata : pend_q;
      end
      if (failsafe_state) begin
         level_d = level_d & ~level_fso_mask;
         pend_d  = pend_d & ~range_fso_mask;
         scale_d = scale_d & ~range_fso_mask;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         level_q <= BPC_LEVEL_RST;
         pend_q  <= BPC_RANGE_RST;
         scale_q <= BPC_RANGE_RST;
      end else begin
         level_q <= level_d;
         pend_q  <= pend_d;
         scale_q <= scale_d;
      end
   end

endmodule

// ---- bpc_regs_tb_top.sv ----
// Self-checking bench for the peak-current register bank.
// Assumes the bank's registered outputs settle two edges after a write is taken.
`timescale 1ns/1ps
module bpc_regs_tb_top;
   import bpc_pkg::*;
   logic                   core_clk;
   logic                   reset;
   logic                   failsafe_state;
   logic [BPC_ADDR_W-1:0]  reg_addr;
   logic                   reg_we;
   logic [BPC_DATA_W-1:0]  reg_wdata;
   logic [BPC_DATA_W-1:0]  reg_rdata;
   logic [BPC_LEVEL_W-1:0] ch1_peak_level;
   logic [BPC_LEVEL_W-1:0] ch2_peak_level;
   logic [BPC_RANGE_W-1:0] ch1_peak_scale;
   logic [BPC_RANGE_W-1:0] ch2_peak_scale;
   logic                   ch1_lowside_lowvolt_en;
   logic                   ch2_lowside_lowvolt_en;
   logic [8:0]             e_l1;
   logic [8:0]             e_l2;
   logic [2:0]             e_s1;
   logic [2:0]             e_s2;
   logic                   e_e1;
   logic                   e_e2;
   logic [2:0]             k;
   int                     bad_count;
   int                     n_checks;
   int                     cyc;

   bpc_regs i_dut (.core_clk(core_clk), .reset(reset), .failsafe_state(failsafe_state), .reg_addr(reg_addr),
      .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ch1_peak_level(ch1_peak_level),
      .ch2_peak_level(ch2_peak_level), .ch1_peak_scale(ch1_peak_scale), .ch2_peak_scale(ch2_peak_scale),
      .ch1_lowside_lowvolt_en(ch1_lowside_lowvolt_en), .ch2_lowside_lowvolt_en(ch2_lowside_lowvolt_en));

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [9:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_we    = 1'b1;
      step(1);
      reg_we    = 1'b0;
      step(3);
   endtask

   task automatic chk_rd(input logic [4:0] a, input logic [9:0] exp);
      reg_addr = a;
      step(2);
      n_checks++;
      if (reg_rdata !== exp) begin
         bad_count++;
         $display("FAIL t=%0t read %h got %h exp %h", $time, a, reg_rdata, exp);
      end
   endtask

   task automatic chk_state();
      logic [25:0] got;
      logic [25:0] exp;
      got = {ch1_peak_level, ch2_peak_level, ch1_peak_scale, ch2_peak_scale,
             ch1_lowside_lowvolt_en, ch2_lowside_lowvolt_en};
      exp = {e_l1, e_l2, e_s1, e_s2, e_e1, e_e2};
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t outputs got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         results();
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1; failsafe_state = 1'b0; reg_addr = 5'h00; reg_we = 1'b0; reg_wdata = 10'h000;
      bad_count = 0; n_checks = 0; cyc = 0;
      {e_l1, e_l2, e_s1, e_s2, e_e1, e_e2} = 26'h0;
      step(8);
      reset = 1'b0;
      chk_state();
      chk_rd(5'h01, 10'h000);
      chk_rd(5'h02, 10'h000);
      chk_rd(5'h03, 10'h000);
      $display("test reset done");
      // Range pends until the level write, bit 9 is dropped
      wr(5'h03, 10'h0A0);
      e_e1 = 1'b1;
      chk_state();
      chk_rd(5'h03, 10'h0A0);
      wr(5'h01, 10'h3FF);
      e_l1 = 9'h1FF; e_s1 = 3'h4;
      chk_state();
      chk_rd(5'h01, 10'h1FF);
      $display("test pending done");
      // Every range code on both channels, each applied only by its own level write
      for (int c = 0; c < 5; c++) begin
         k = c[2:0];
         wr(5'h03, {2'b00, k[0], k[1], k, k});
         e_e1 = k[0]; e_e2 = k[1];
         chk_state();
         wr(5'h01, {4'h0, k, 3'h5});
         e_l1 = {3'h0, k, 3'h5}; e_s1 = k;
         chk_state();
         wr(5'h02, {1'b1, 9'h0DB});
         e_l2 = 9'h0DB; e_s2 = k;
         chk_state();
         chk_rd(5'h02, 10'h0DB);
         chk_rd(5'h03, {2'b00, k[0], k[1], k, k});
      end
      $display("test codes done");
      // Out-of-range codes act as the highest range
      wr(5'h03, 10'h03F);
      e_e1 = 1'b0; e_e2 = 1'b0;
      chk_rd(5'h03, 10'h024);
      wr(5'h01, 10'h000);
      e_l1 = 9'h000; e_s1 = 3'h4;
      chk_state();
      // Unmapped places ignore writes and read zero
      wr(5'h05, 10'h3FF);
      wr(5'h00, 10'h3FF);
      chk_rd(5'h05, 10'h000);
      chk_state();
      $display("test clamp unmapped done");
      // Fail-safe clears only the marked fields
      wr(5'h03, 10'h0DB);
      wr(5'h01, 10'h1FF);
      wr(5'h02, 10'h1FF);
      failsafe_state = 1'b1;
      step(2);
      failsafe_state = 1'b0;
      step(2);
      {e_l1, e_l2, e_s1, e_s2, e_e1, e_e2} = {9'h001, 9'h001, 3'h0, 3'h0, 1'b1, 1'b1};
      chk_state();
      chk_rd(5'h03, 10'h0C0);
      $display("test failsafe done");
      // Reset in mid-run clears everything again
      reset = 1'b1;
      step(2);
      reset = 1'b0;
      {e_l1, e_l2, e_s1, e_s2, e_e1, e_e2} = 26'h0;
      chk_state();
      chk_rd(5'h03, 10'h000);
      $display("test midrun reset done");
      results();
   end
endmodule
